/* ahbmr_master.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// R01: Protection bit zero marks data, not fetch
// R02: Protection bit one marks privileged access
// R03: Bits two, three mark bufferable and cachable
// R04: Slaves avoid depending on protection bits
// R05: A started transfer is never cancelled
// R06: Every accessed slave answers with code, ready
// R07: Transfer completes only when ready high
// R08: Slave wait states bounded, at most sixteen
// R09: Okay with ready is success, also waits
// R10: Error is two cycles, transfer failed
// R11: Retry is two cycles, reissue until done
// R12: Split is two cycles, reissue when granted; this master has no grant and reissues at once, as for retry
// R13: Separate read and write buses, no tristate
// R14: Write data held stable through waits
// R15: Transfers aligned to their own size
// R16: Narrow write data replicated on all lanes
// R17: Everything on rising edge of clock
// R18: Only byte, halfword and word sizes
// R19: Error reported to core as abort
module ahbmr_master (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Bus side
  ahbmr_bus_if.mst         bus,
  // Request from the core
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_fetch,
  input  wire logic        req_priv,
  input  wire logic        req_buf,
  input  wire logic        req_cache,
  input  wire logic [2:0]  req_size,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  // Answer to the core
  output logic             rsp_done,
  output logic             rsp_abort,
  output logic             rsp_misalign,
  output logic [31:0]      rsp_rdata,
  output logic             rsp_busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ahbmr_pkg::ahbmr_mst_state_t state;
  ahbmr_pkg::ahbmr_mst_state_t next_state;
  logic [31:0] wdata_hold, next_wdata_hold;
  logic [1:0]  next_htrans;
  logic [31:0] next_haddr;
  logic        next_hwrite;
  logic [2:0]  next_hsize;
  logic [3:0]  next_hprot;
  logic [31:0] next_hwdata;
  logic        next_req_ready;
  logic        next_rsp_done;
  logic        next_rsp_abort;
  logic        next_rsp_misalign;
  logic [31:0] next_rsp_rdata;
  logic        next_rsp_busy;
  logic        take;
  logic        legal;
  logic [3:0]  prot_word;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------

  // Request taken when idle and offered
  assign take = req_valid && req_ready;

  // R15: Alignment checked
  // R18: Size checked
  assign legal = ahbmr_pkg::size_ok(req_size) &&
                 ahbmr_pkg::is_aligned(req_size, req_addr);

  // Protection attributes packed per access
  always_comb begin
    prot_word = ahbmr_pkg::RST_PROT;
    // R01: Data not fetch
    prot_word[ahbmr_pkg::PROT_DATA_BIT]  = ~req_fetch;
    // R02: Privileged mode
    prot_word[ahbmr_pkg::PROT_PRIV_BIT]  = req_priv;
    // R03: Buffer and cache
    prot_word[ahbmr_pkg::PROT_BUF_BIT]   = req_buf;
    prot_word[ahbmr_pkg::PROT_CACHE_BIT] = req_cache;
  end

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------

  // Next values for bus and core answer
  always_comb begin
    next_state        = state;
    next_wdata_hold   = wdata_hold;
    next_htrans       = bus.htrans;
    next_haddr        = bus.haddr;
    next_hwrite       = bus.hwrite;
    next_hsize        = bus.hsize;
    next_hprot        = bus.hprot;
    next_hwdata       = bus.hwdata;
    next_rsp_done     = 1'b0;
    next_rsp_abort    = 1'b0;
    next_rsp_misalign = 1'b0;
    next_rsp_rdata    = rsp_rdata;
    case (state)
      ahbmr_pkg::M_IDLE: begin
        if (take) begin
          if (!legal) begin
            // Refused without any bus activity
            next_rsp_misalign = 1'b1;
          end else begin
            next_htrans     = ahbmr_pkg::TRANS_NONSEQ;
            next_haddr      = req_addr;
            next_hwrite     = req_write;
            next_hsize      = req_size;
            next_hprot      = prot_word;
            // R16: Lanes replicated
            next_wdata_hold = ahbmr_pkg::replicate(req_size, req_wdata);
            next_state      = ahbmr_pkg::M_ADDR;
          end
        end
      end
      ahbmr_pkg::M_ADDR: begin
        // R17: Address phase ends on a ready edge
        if (bus.hready) begin
          next_htrans = ahbmr_pkg::TRANS_IDLE;
          if (bus.hwrite) begin
            next_hwdata = wdata_hold;
          end
          next_state = ahbmr_pkg::M_DATA;
        end
      end
      ahbmr_pkg::M_DATA: begin
        // R05: No cancel, slave decides
        // R07: Complete only on ready
        // R14: Write data held meanwhile
        if (bus.hready) begin
          case (bus.hresp)
            ahbmr_pkg::RESP_OKAY: begin
              // R09: Okay completes
              next_rsp_done = 1'b1;
              if (!bus.hwrite) begin
                next_rsp_rdata = bus.hrdata;
              end
              next_state = ahbmr_pkg::M_IDLE;
            end
            ahbmr_pkg::RESP_ERROR: begin
              // R10: Error ends transfer
              // R19: Abort, data discarded
              next_rsp_done  = 1'b1;
              next_rsp_abort = 1'b1;
              next_rsp_rdata = ahbmr_pkg::RST_WORD;
              next_state     = ahbmr_pkg::M_IDLE;
            end
            default: begin
              // R11: Retry reissued
              // R12: Split reissued
              next_htrans = ahbmr_pkg::TRANS_NONSEQ;
              next_state  = ahbmr_pkg::M_ADDR;
            end
          endcase
        end
      end
      default: begin
        next_state  = ahbmr_pkg::M_IDLE;
        next_htrans = ahbmr_pkg::TRANS_IDLE;
      end
    endcase
    // Ready and busy follow the state being entered
    next_req_ready = (next_state == ahbmr_pkg::M_IDLE);
    next_rsp_busy  = (next_state != ahbmr_pkg::M_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // R13: Separate write bus, always driven
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state        <= ahbmr_pkg::M_IDLE;
      wdata_hold   <= ahbmr_pkg::RST_WORD;
      bus.htrans   <= ahbmr_pkg::TRANS_IDLE;
      bus.haddr    <= ahbmr_pkg::RST_WORD;
      bus.hwrite   <= 1'b0;
      bus.hsize    <= ahbmr_pkg::RST_SIZE;
      bus.hprot    <= ahbmr_pkg::RST_PROT;
      bus.hwdata   <= ahbmr_pkg::RST_WORD;
      req_ready    <= 1'b0;
      rsp_done     <= 1'b0;
      rsp_abort    <= 1'b0;
      rsp_misalign <= 1'b0;
      rsp_rdata    <= ahbmr_pkg::RST_WORD;
      rsp_busy     <= 1'b0;
    end else begin
      state        <= next_state;
      wdata_hold   <= next_wdata_hold;
      bus.htrans   <= next_htrans;
      bus.haddr    <= next_haddr;
      bus.hwrite   <= next_hwrite;
      bus.hsize    <= next_hsize;
      bus.hprot    <= next_hprot;
      bus.hwdata   <= next_hwdata;
      req_ready    <= next_req_ready;
      rsp_done     <= next_rsp_done;
      rsp_abort    <= next_rsp_abort;
      rsp_misalign <= next_rsp_misalign;
      rsp_rdata    <= next_rsp_rdata;
      rsp_busy     <= next_rsp_busy;
    end
  end

endmodule : ahbmr_master
`default_nettype wire

/* ahbmr_pkg.sv */
`default_nettype none
package ahbmr_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Transfer type, size and response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SIZE_BYTE    = 3'h0;
  localparam logic [2:0] SIZE_HALF    = 3'h1;
  localparam logic [2:0] SIZE_WORD    = 3'h2;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_ERROR   = 2'h1;
  localparam logic [1:0] RESP_RETRY   = 2'h2;
  localparam logic [1:0] RESP_SPLIT   = 2'h3;

  // ----------------------------------------------------------------
  // Protection bus field positions
  // ----------------------------------------------------------------
  localparam int unsigned PROT_DATA_BIT  = 0;
  localparam int unsigned PROT_PRIV_BIT  = 1;
  localparam int unsigned PROT_BUF_BIT   = 2;
  localparam int unsigned PROT_CACHE_BIT = 3;

  // ----------------------------------------------------------------
  // Wait state limit and values after reset
  // ----------------------------------------------------------------
  localparam int unsigned MAX_WAITS = 16;
  localparam int unsigned WAIT_W    = 5;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [3:0]  RST_PROT  = 4'h0;
  localparam logic [2:0]  RST_SIZE  = 3'h0;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA} ahbmr_mst_state_t;
  typedef enum logic [1:0] {S_FREE, S_WAIT, S_RESP1} ahbmr_slv_state_t;

  // Size is one the master may generate
  function automatic logic size_ok(input logic [2:0] size);
    size_ok = (size == SIZE_BYTE) || (size == SIZE_HALF) ||
              (size == SIZE_WORD);
  endfunction : size_ok

  // Address sits on a boundary of the transfer size
  function automatic logic is_aligned(input logic [2:0]  size,
                                      input logic [31:0] addr);
    is_aligned = (size == SIZE_WORD) ? (addr[1:0] == 2'h0) :
                 (size == SIZE_HALF) ? (addr[0] == 1'b0) : 1'b1;
  endfunction : is_aligned

  // Copies the low byte or halfword into every lane
  function automatic logic [31:0] replicate(input logic [2:0]  size,
                                            input logic [31:0] data);
    replicate = (size == SIZE_BYTE) ? {4{data[7:0]}} :
                (size == SIZE_HALF) ? {2{data[15:0]}} : data;
  endfunction : replicate

endpackage : ahbmr_pkg
`default_nettype wire

/* ahbmr_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ahbmr_bus_if;

  // ----------------------------------------------------------------
  // Address, control and data signals
  // ----------------------------------------------------------------
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [3:0]  hprot;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic [1:0]  hresp;

  // Master end
  modport mst (
    output htrans, haddr, hwrite, hsize, hprot, hwdata,
    input  hrdata, hready, hresp
  );

  // Slave end
  modport slv (
    input  htrans, haddr, hwrite, hsize, hprot, hwdata,
    output hrdata, hready, hresp
  );

endinterface : ahbmr_bus_if
`default_nettype wire

/* ahbmr_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module ahbmr_slave #(
  parameter int unsigned MAX_WAITS = ahbmr_pkg::MAX_WAITS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Bus side
  ahbmr_bus_if.slv         bus,
  // Response control from user logic
  input  wire logic [4:0]  cfg_waits,
  input  wire logic [1:0]  cfg_resp,
  input  wire logic [31:0] rd_data,
  // Access report
  output logic             acc_valid,
  output logic             acc_write,
  output logic [31:0]      acc_addr,
  output logic [2:0]       acc_size,
  output logic [3:0]       acc_prot,
  output logic             wr_valid,
  output logic [31:0]      wr_data
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (MAX_WAITS > 31) begin : g_bad_waits
    $error("MAX_WAITS does not fit the wait counter");
  end

  localparam logic [4:0] WAIT_CAP = MAX_WAITS[4:0];

  ahbmr_pkg::ahbmr_slv_state_t state;
  ahbmr_pkg::ahbmr_slv_state_t next_state;
  logic [4:0]  cnt,  next_cnt;
  logic [1:0]  code, next_code;
  logic        dp_write, next_dp_write;
  logic        next_hready;
  logic [1:0]  next_hresp;
  logic [31:0] next_hrdata;
  logic        next_acc_valid, next_acc_write;
  logic [31:0] next_acc_addr;
  logic [2:0]  next_acc_size;
  logic [3:0]  next_acc_prot;
  logic        next_wr_valid;
  logic [31:0] next_wr_data;
  logic        final_now;
  logic [1:0]  final_code;

  // ----------------------------------------------------------------
  // Response sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_code      = code;
    next_dp_write  = dp_write;
    next_hready    = bus.hready;
    next_hresp     = bus.hresp;
    next_hrdata    = bus.hrdata;
    next_acc_valid = 1'b0;
    next_acc_write = acc_write;
    next_acc_addr  = acc_addr;
    next_acc_size  = acc_size;
    next_acc_prot  = acc_prot;
    next_wr_valid  = 1'b0;
    next_wr_data   = wr_data;
    final_now      = 1'b0;
    final_code     = code;
    // R07: Write data taken when ready
    if (bus.hready && dp_write && bus.hresp == ahbmr_pkg::RESP_OKAY) begin
      next_wr_valid = 1'b1;
      next_wr_data  = bus.hwdata;
    end
    case (state)
      ahbmr_pkg::S_FREE: begin
        if (bus.htrans[1]) begin
          next_acc_valid = 1'b1;
          next_acc_write = bus.hwrite;
          next_acc_addr  = bus.haddr;
          next_acc_size  = bus.hsize;
          // R04: Protection only passed on
          next_acc_prot  = bus.hprot;
          next_dp_write  = bus.hwrite;
          next_code      = cfg_resp;
          final_code     = cfg_resp;
          // R08: Wait count capped
          next_cnt = (cfg_waits > WAIT_CAP) ? WAIT_CAP : cfg_waits;
          if (next_cnt == 5'h00) begin
            final_now = 1'b1;
          end else begin
            // R09: Okay while waiting
            next_hready = 1'b0;
            next_hresp  = ahbmr_pkg::RESP_OKAY;
            next_state  = ahbmr_pkg::S_WAIT;
          end
        end else begin
          // Idle slots get a zero wait okay
          next_hready   = 1'b1;
          next_hresp    = ahbmr_pkg::RESP_OKAY;
          next_dp_write = 1'b0;
        end
      end
      ahbmr_pkg::S_WAIT: begin
        next_cnt = cnt - 5'h01;
        if (cnt == 5'h01) begin
          final_now = 1'b1;
        end
      end
      ahbmr_pkg::S_RESP1: begin
        // R10: Second response cycle
        next_hready = 1'b1;
        next_state  = ahbmr_pkg::S_FREE;
      end
      default: begin
        next_state  = ahbmr_pkg::S_FREE;
        next_hready = 1'b1;
        next_hresp  = ahbmr_pkg::RESP_OKAY;
      end
    endcase
    // R06: Response on code and ready
    if (final_now) begin
      next_hresp = final_code;
      if (final_code == ahbmr_pkg::RESP_OKAY) begin
        next_hready = 1'b1;
        next_hrdata = rd_data;
        next_state  = ahbmr_pkg::S_FREE;
      end else begin
        // R11: Two cycle non okay
        next_hready = 1'b0;
        next_state  = ahbmr_pkg::S_RESP1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state      <= ahbmr_pkg::S_FREE;
      cnt        <= 5'h00;
      code       <= ahbmr_pkg::RESP_OKAY;
      dp_write   <= 1'b0;
      bus.hready <= 1'b1;
      bus.hresp  <= ahbmr_pkg::RESP_OKAY;
      bus.hrdata <= ahbmr_pkg::RST_WORD;
      acc_valid  <= 1'b0;
      acc_write  <= 1'b0;
      acc_addr   <= ahbmr_pkg::RST_WORD;
      acc_size   <= ahbmr_pkg::RST_SIZE;
      acc_prot   <= ahbmr_pkg::RST_PROT;
      wr_valid   <= 1'b0;
      wr_data    <= ahbmr_pkg::RST_WORD;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      code       <= next_code;
      dp_write   <= next_dp_write;
      bus.hready <= next_hready;
      bus.hresp  <= next_hresp;
      bus.hrdata <= next_hrdata;
      acc_valid  <= next_acc_valid;
      acc_write  <= next_acc_write;
      acc_addr   <= next_acc_addr;
      acc_size   <= next_acc_size;
      acc_prot   <= next_acc_prot;
      wr_valid   <= next_wr_valid;
      wr_data    <= next_wr_data;
    end
  end

endmodule : ahbmr_slave
`default_nettype wire

/* ahbmr_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ahbmr_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Bus signals
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [3:0]  hprot,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hready,
  input wire logic [1:0]  hresp
);
  // ----------------------------------------------------------------
  // Data phase record
  // ----------------------------------------------------------------
  logic        acc;
  logic        dphase, next_dphase;
  logic        dwr, next_dwr;
  logic [2:0]  dsize, next_dsize;
  logic [31:0] daddr, next_daddr;

  // Tracks the transfer whose data phase is open
  always_comb begin
    acc = htrans[1] && hready;
    next_dphase = acc || (dphase && !hready);
    next_dwr = acc ? hwrite : dwr;
    next_dsize = acc ? hsize : dsize;
    next_daddr = acc ? haddr : daddr;
  end

  // Registers the record
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dphase <= 1'b0;
      dwr <= 1'b0;
      dsize <= 3'h0;
      daddr <= 32'h0000_0000;
    end else begin
      dphase <= next_dphase;
      dwr <= next_dwr;
      dsize <= next_dsize;
      daddr <= next_daddr;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_wdata_held: assert property (
    dphase && dwr && !hready |=> $stable(hwdata))
    else $error("write data moved during a wait");
  a_byte_lanes: assert property (
    dphase && dwr && dsize == ahbmr_pkg::SIZE_BYTE
    |-> hwdata == {4{hwdata[7:0]}})
    else $error("byte not on all lanes");
  a_half_lanes: assert property (
    dphase && dwr && dsize == ahbmr_pkg::SIZE_HALF
    |-> hwdata == {2{hwdata[15:0]}})
    else $error("halfword not on both halves");
  a_addr_aligned: assert property (
    htrans[1] |-> (hsize != ahbmr_pkg::SIZE_WORD || haddr[1:0] == 2'h0)
    && (hsize != ahbmr_pkg::SIZE_HALF || !haddr[0]))
    else $error("transfer not size aligned");
  a_size_legal: assert property (
    htrans[1] |-> hsize <= ahbmr_pkg::SIZE_WORD)
    else $error("illegal transfer size");
  a_no_new_xfer: assert property (
    dphase && !hready |-> htrans == ahbmr_pkg::TRANS_IDLE)
    else $error("new transfer during open data phase");
  a_resp_two_cyc: assert property (
    hresp != ahbmr_pkg::RESP_OKAY && !hready
    |=> hready && hresp == $past(hresp))
    else $error("response not two cycles");
  a_okay_waits: assert property (
    hresp != ahbmr_pkg::RESP_OKAY && !hready
    |-> $past(hresp) == ahbmr_pkg::RESP_OKAY)
    else $error("wait cycle not okay");
  a_retry_reissue: assert property (
    dphase && hready && hresp[1]
    |=> htrans == ahbmr_pkg::TRANS_NONSEQ && haddr == daddr)
    else $error("transfer not reissued");
  a_wait_bound: assert property (
    $fell(hready) |-> ##[1:18] hready)
    else $error("too many wait states");
endmodule : ahbmr_props
`default_nettype wire

/* ahb_master_response_and_write_data_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module ahb_master_response_and_write_data_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys, rst, req_valid, req_write, req_fetch, req_priv;
  logic        req_buf, req_cache, req_ready, rsp_done, rsp_abort;
  logic        rsp_misalign, rsp_busy, acc_valid, acc_write, wr_valid;
  logic [2:0]  req_size, acc_size;
  logic [31:0] req_addr, req_wdata, rsp_rdata, rd_data, acc_addr, wr_data;
  logic [4:0]  cfg_waits;
  logic [1:0]  cfg_resp, resp_want;
  logic        resp_load;
  logic [3:0]  acc_prot;
  int          mismatches, comparisons;

  ahbmr_bus_if bus ();

  // Both ends joined, checker beside the bus
  ahbmr_master ahbmr_master_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .req_valid(req_valid), .req_write(req_write), .req_fetch(req_fetch),
    .req_priv(req_priv), .req_buf(req_buf), .req_cache(req_cache),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_done(rsp_done), .rsp_abort(rsp_abort),
    .rsp_misalign(rsp_misalign), .rsp_rdata(rsp_rdata),
    .rsp_busy(rsp_busy));
  ahbmr_slave ahbmr_slave_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .cfg_waits(cfg_waits), .cfg_resp(cfg_resp), .rd_data(rd_data),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_size(acc_size), .acc_prot(acc_prot), .wr_valid(wr_valid),
    .wr_data(wr_data));
  ahbmr_props ahbmr_props_inst (.clk_sys(clk_sys), .rst(rst),
    .htrans(bus.htrans), .haddr(bus.haddr), .hwrite(bus.hwrite),
    .hsize(bus.hsize), .hprot(bus.hprot), .hwdata(bus.hwdata),
    .hrdata(bus.hrdata), .hready(bus.hready), .hresp(bus.hresp));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Issues one request and follows it to completion
  task automatic xfer(input logic w, f, p, b, c, input logic [2:0] sz,
    input logic [31:0] a, d, input logic [4:0] wt, input logic [1:0] rs);
    logic [31:0] exp_w;
    int          accs, wrs, n, wc, exp_n;
    exp_w = (sz == 3'h0) ? {4{d[7:0]}} : (sz == 3'h1) ? {2{d[15:0]}} : d;
    wc = (wt > ahbmr_pkg::MAX_WAITS) ? ahbmr_pkg::MAX_WAITS : wt;
    exp_n = rs[1] ? 2 * wc + 6 : (rs == 2'h1) ? wc + 4 : wc + 3;
    accs = 0;
    wrs = 0;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_fetch <= f;
    req_priv <= p;
    req_buf <= b;
    req_cache <= c;
    req_size <= sz;
    req_addr <= a;
    req_wdata <= d;
    rd_data <= d;
    cfg_waits <= wt;
    resp_want <= rs;
    resp_load <= 1'b1;
    do @(negedge clk_sys); while (!req_ready);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    resp_load <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
      if (wr_valid) begin
        wrs++;
        check("wr_data", exp_w, wr_data);
      end
      if (acc_valid) begin
        accs++;
        check("acc_prot", {28'h0, c, b, p, ~f},
              {28'h0, acc_prot});
        check("acc_addr", a, acc_addr);
        check("acc_write", {31'h0, w}, {31'h0, acc_write});
        check("acc_size", {29'h0, sz}, {29'h0, acc_size});
        check("rsp_busy", 32'h1, {31'h0, rsp_busy});
      end
    end while (!rsp_done && n < 200);
    check("rsp_done", 32'h1, {31'h0, rsp_done});
    check("cycles", exp_n, n);
    check("rsp_abort", {31'h0, rs == 2'h1}, {31'h0, rsp_abort});
    check("accesses", rs[1] ? 2 : 1, accs);
    @(negedge clk_sys);
    wrs += wr_valid;
    check("wr_count", {31'h0, w && rs != 2'h1}, wrs);
    if (!w) begin
      // Read data or cleared
      check("rsp_rdata", (rs == 2'h1) ? 32'h0 : d, rsp_rdata);
    end
  endtask : xfer

  // Offers a request the master must refuse
  task automatic refuse(input logic [2:0] sz, input logic [31:0] a);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_size <= sz;
    req_addr <= a;
    do @(negedge clk_sys); while (!req_ready);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    check("rsp_misalign", 32'h1, {31'h0, rsp_misalign});
    check("req_ready", 32'h1, {31'h0, req_ready});
  endtask : refuse

  // ----------------------------------------------------------------
  // Clock, responses and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Loads the wanted response; retried transfers then end okay
  always @(posedge clk_sys) begin
    if (rst || acc_valid) begin
      cfg_resp <= ahbmr_pkg::RESP_OKAY;
    end else if (resp_load) begin
      cfg_resp <= resp_want;
    end
  end

  // Cuts a hang short
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {req_valid, req_write, req_fetch, req_priv, req_buf, req_cache} = '0;
    req_size = 3'h0;
    req_addr = 32'h0000_0000;
    req_wdata = 32'h0000_0000;
    rd_data = 32'h0000_0000;
    cfg_waits = 5'h00;
    resp_want = 2'h0;
    resp_load = 1'b0;
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(1, 0, 1, 1, 0, 3'h2, 32'h0000_1000, 32'hCAFE_F00D, 5'h00, 2'h0);
    xfer(1, 0, 0, 0, 1, 3'h1, 32'h0000_1002, 32'h0000_1234, 5'h03, 2'h0);
    xfer(1, 0, 1, 0, 1, 3'h0, 32'h0000_1003, 32'h0000_0012, 5'h14, 2'h0);
    xfer(0, 1, 0, 1, 0, 3'h2, 32'h0000_2000, 32'h89AB_CDEF, 5'h02, 2'h0);
    xfer(0, 0, 1, 0, 0, 3'h2, 32'h0000_2004, 32'h5555_AAAA, 5'h02, 2'h1);
    xfer(1, 0, 0, 1, 1, 3'h1, 32'h0000_2006, 32'h0000_BEEF, 5'h00, 2'h1);
    xfer(1, 0, 1, 1, 1, 3'h2, 32'h0000_3000, 32'h1357_9BDF, 5'h01, 2'h2);
    xfer(0, 1, 1, 0, 1, 3'h0, 32'h0000_3001, 32'h0000_0077, 5'h00, 2'h3);
    refuse(3'h2, 32'h0000_1002);
    refuse(3'h1, 32'h0000_1001);
    refuse(3'h3, 32'h0000_1000);
    give_verdict();
  end
endmodule : ahb_master_response_and_write_data_bench
`default_nettype wire
